// File: rtl/sfsfe_pkg.sv
/*
   Shared constants of the serial flash front end: memory geometry,
   opcodes, status bit positions and cycle timing.
   Assumes a core clock of 200 MHz.
*/
package sfsfe_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int SECTOR_W = 6;
   localparam int PAGE_W = 8;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = SECTOR_W + PAGE_W + BYTE_W;
   localparam int SECTOR_LSB = PAGE_W + BYTE_W;
   localparam int PAGE_LSB = BYTE_W;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [1:0] ADDR_BYTES = 2'h3;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
   localparam logic [7:0] OP_BULK_ERASE = 8'hc7;

   // ----------------------------------------------------------------
   // status byte
   // ----------------------------------------------------------------
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam logic [7:0] STAT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int PROG_TIME_NS = 20000;
   localparam int ERASE_TIME_NS = 40000;
   localparam int PROG_CYCLES =
      (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES =
      (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_W = 16;

   typedef enum logic [1:0] {
      ST_OPCODE,
      ST_ADDR,
      ST_DATA,
      ST_IGNORE
   } sfsfe_state_t;
endpackage : sfsfe_pkg

// File: rtl/sfsfe_sync.sv
/*
   Two flip-flop level synchroniser, any width.
   Assumes each bit is a level or a slow toggle.
*/
module sfsfe_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule : sfsfe_sync

// File: rtl/sfsfe_link.sv
/*
   Serial-clock side of the front end: input shifting on rising edges,
   output shifting on falling edges, hold pause, byte hand-off by toggle.
   Assumes link_rst is high while the device is deselected.
*/
module sfsfe_link
   import sfsfe_pkg::*;
(
   input wire logic sck,
   input wire logic reset,
   input wire logic link_rst,
   input wire logic hold_n,
   input wire logic mosi,
   input wire logic [7:0] status_in,
   output logic [7:0] byte_q,
   output logic byte_tgl_q,
   output logic miso_q,
   output logic miso_oe_q
);
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [6:0] sr_q, sr_d;
   logic first_q, first_d;
   logic rd_q, rd_d;
   logic [7:0] out_q, out_d;
   logic [7:0] byte_d;
   logic byte_tgl_d;
   logic miso_d, miso_oe_d;
   logic [7:0] status_s;
   logic [7:0] rx;
   logic oe_rst;

   sfsfe_sync #(.W(8), .RST_VAL(STAT_RESET)) u_stat_sync (
      .clk(sck),
      .reset(link_rst),
      .d(status_in),
      .q(status_s)
   );

   // ----------------------------------------------------------------
   // rising edge: sample input
   // ----------------------------------------------------------------
   always_comb begin
      rx = {sr_q, mosi};
      bit_cnt_d = bit_cnt_q;
      sr_d = sr_q;
      first_d = first_q;
      rd_d = rd_q;
      out_d = out_q;
      byte_d = byte_q;
      byte_tgl_d = byte_tgl_q;
      if (hold_n) begin
         bit_cnt_d = bit_cnt_q + 3'h1;
         sr_d = rx[6:0];
         if (bit_cnt_q == 3'h7) begin
            byte_d = rx;
            byte_tgl_d = ~byte_tgl_q;
            first_d = 1'b0;
            out_d = status_s;
            if (first_q && rx == OP_READ_STATUS) begin
               rd_d = 1'b1;
            end
         end
      end
   end

   // byte hand-off survives deselect so no toggle is lost
   always_ff @(posedge sck or posedge reset) begin
      if (reset) begin
         byte_q <= 8'h00;
         byte_tgl_q <= 1'b0;
      end else begin
         byte_q <= byte_d;
         byte_tgl_q <= byte_tgl_d;
      end
   end

   always_ff @(posedge sck or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_q <= 3'h0;
         sr_q <= 7'h00;
         first_q <= 1'b1;
         rd_q <= 1'b0;
         out_q <= STAT_RESET;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         sr_q <= sr_d;
         first_q <= first_d;
         rd_q <= rd_d;
         out_q <= out_d;
      end
   end

   // ----------------------------------------------------------------
   // falling edge: drive output
   // ----------------------------------------------------------------
   assign oe_rst = link_rst | ~hold_n;

   always_comb begin
      miso_d = out_q[3'h7 - bit_cnt_q];
      miso_oe_d = rd_q;
   end

   always_ff @(negedge sck or posedge oe_rst) begin
      if (oe_rst) begin
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_q <= miso_d;
         miso_oe_q <= miso_oe_d;
      end
   end

   AST_HOLD_FREEZE: assert property (@(posedge sck) disable iff (link_rst)
      !hold_n |=> $stable(bit_cnt_q) && $stable(sr_q))
      else $error("shift state moved during hold");

   AST_BIT_ADVANCE: assert property (@(posedge sck) disable iff (link_rst)
      hold_n |=> bit_cnt_q == 3'($past(bit_cnt_q) + 3'h1))
      else $error("bit counter did not advance on rising edge");

   AST_HOLD_QUIET: assert property (@(posedge sck) disable iff (reset)
      (!hold_n || link_rst) |-> !miso_oe_q)
      else $error("output driven during hold or deselect");
endmodule : sfsfe_link

// File: rtl/sfsfe_top.sv
/*
   Serial flash front end, device side: decodes the serial command
   stream into program and erase requests with sector/page/byte address,
   keeps the write-enable latch, busy timer and standby/active state.
   Assumes a bus master in serial mode 0 or 3 on sck, sel_n, mosi and
   hold_n; the array itself sits outside and consumes the requests.
*/
// How it works
// - output bit changes after falling clock edge
// - input sampled on every rising clock edge outside hold
// - opcode, then address, then data bytes
// - select high floats the output
// - deselected goes standby after internal cycle
// - select low makes device active
// - no instruction before first select falling edge; read status is still answered on miso_o before it
// - hold pauses transfer, keeps selection and command
// - hold floats output, ignores clock and data
// - 64 sectors of 256 pages of 256 bytes
// - page program takes one to 256 bytes
// - bulk erase and single sector erase
// - modifying commands need write-enable latch set
module sfsfe_top
   import sfsfe_pkg::*;
#(
   parameter int PROG_CNT = PROG_CYCLES,
   parameter int ERASE_CNT = ERASE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic hold_n,
   output logic miso_o,
   output logic miso_oe,
   output logic prog_valid,
   output logic [SECTOR_W-1:0] prog_sector,
   output logic [PAGE_W-1:0] prog_page,
   output logic [BYTE_W-1:0] prog_byte,
   output logic [7:0] prog_data,
   output logic erase_sector_valid,
   output logic [SECTOR_W-1:0] erase_sector,
   output logic erase_all_valid,
   output logic busy,
   output logic standby,
   output logic write_enable_latch
);
   localparam logic [BUSY_W-1:0] PROG_LOAD = BUSY_W'(PROG_CNT);
   localparam logic [BUSY_W-1:0] ERASE_LOAD = BUSY_W'(ERASE_CNT);

   // ----------------------------------------------------------------
   // link side and crossings
   // ----------------------------------------------------------------
   logic link_rst;
   logic [7:0] link_byte;
   logic link_tgl;
   logic [7:0] status_q, status_d;
   logic [1:0] sync_s;
   logic tgl_s, sel_s;

   assign link_rst = reset | sel_n;

   sfsfe_link u_link (
      .sck(sck),
      .reset(reset),
      .link_rst(link_rst),
      .hold_n(hold_n),
      .mosi(mosi),
      .status_in(status_q),
      .byte_q(link_byte),
      .byte_tgl_q(link_tgl),
      .miso_q(miso_o),
      .miso_oe_q(miso_oe)
   );

   // select resets to low so a select already low at reset is no edge
   sfsfe_sync #(.W(2), .RST_VAL(2'h0)) u_sync (
      .clk(clk),
      .reset(reset),
      .d({link_tgl, sel_n}),
      .q(sync_s)
   );

   assign tgl_s = sync_s[1];
   assign sel_s = sync_s[0];

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   sfsfe_state_t state_q, state_d;
   logic tgl_seen_q, tgl_seen_d;
   logic sel_prev_q, sel_prev_d;
   logic armed_q, armed_d;
   logic [7:0] opcode_q, opcode_d;
   logic [1:0] addr_cnt_q, addr_cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [8:0] data_cnt_q, data_cnt_d;
   logic latch_q, latch_d;
   logic [BUSY_W-1:0] busy_cnt_q, busy_cnt_d;
   logic prog_valid_d;
   logic [7:0] prog_data_d;
   logic [ADDR_W-1:0] prog_addr_q, prog_addr_d;
   logic erase_sector_valid_d, erase_all_valid_d;
   logic [SECTOR_W-1:0] erase_sector_d;
   logic standby_d;
   logic byte_evt, frame_start, frame_end, idle, may_modify;

   function automatic logic [ADDR_W-1:0] next_in_page(
      input logic [ADDR_W-1:0] a
   );
      // byte index wraps inside the page
      next_in_page = {a[ADDR_W-1:PAGE_LSB], a[BYTE_W-1:0] + 8'h01};
   endfunction : next_in_page

   always_comb begin
      byte_evt = armed_q && (tgl_s != tgl_seen_q);
      frame_start = sel_prev_q && !sel_s;
      frame_end = armed_q && !sel_prev_q && sel_s;
      idle = busy_cnt_q == '0;
      may_modify = latch_q && idle;
      state_d = state_q;
      tgl_seen_d = tgl_s;
      sel_prev_d = sel_s;
      armed_d = armed_q;
      opcode_d = opcode_q;
      addr_cnt_d = addr_cnt_q;
      addr_d = addr_q;
      data_cnt_d = data_cnt_q;
      latch_d = latch_q;
      busy_cnt_d = idle ? busy_cnt_q : busy_cnt_q - 1'b1;
      prog_valid_d = 1'b0;
      prog_data_d = prog_data;
      prog_addr_d = prog_addr_q;
      erase_sector_valid_d = 1'b0;
      erase_all_valid_d = 1'b0;
      erase_sector_d = erase_sector;
      if (busy_cnt_q == BUSY_W'(1)) begin
         latch_d = 1'b0;
      end
      if (frame_start) begin
         armed_d = 1'b1;
         // no opcode of an earlier frame acts at the end of an empty one
         opcode_d = 8'h00;
         state_d = ST_OPCODE;
         addr_cnt_d = 2'h0;
         data_cnt_d = 9'h000;
      end else if (byte_evt) begin
         unique case (state_q)
            ST_OPCODE: begin
               opcode_d = link_byte;
               if (link_byte == OP_PAGE_PROGRAM ||
                   link_byte == OP_SECTOR_ERASE) begin
                  state_d = ST_ADDR;
               end else begin
                  state_d = ST_IGNORE;
               end
            end
            ST_ADDR: begin
               addr_d = ADDR_W'({addr_q, link_byte});
               addr_cnt_d = addr_cnt_q + 2'h1;
               if (addr_cnt_q == ADDR_BYTES - 2'h1) begin
                  state_d = opcode_q == OP_PAGE_PROGRAM ?
                            ST_DATA : ST_IGNORE;
                  prog_addr_d = ADDR_W'({addr_q, link_byte});
               end
            end
            ST_DATA: begin
               if (may_modify && data_cnt_q != PAGE_BYTES) begin
                  prog_valid_d = 1'b1;
                  prog_data_d = link_byte;
                  data_cnt_d = data_cnt_q + 9'h001;
               end
            end
            ST_IGNORE: begin
            end
         endcase
      end
      if (prog_valid) begin
         prog_addr_d = next_in_page(prog_addr_q);
      end
      if (frame_end && idle) begin
         unique case (opcode_q)
            OP_WRITE_ENABLE: latch_d = state_q != ST_OPCODE;
            OP_WRITE_DISABLE: latch_d = state_q == ST_OPCODE && latch_q;
            OP_PAGE_PROGRAM: begin
               if (data_cnt_q != 9'h000) begin
                  busy_cnt_d = PROG_LOAD;
               end
            end
            OP_SECTOR_ERASE: begin
               if (state_q == ST_IGNORE && latch_q) begin
                  erase_sector_valid_d = 1'b1;
                  erase_sector_d = addr_q[ADDR_W-1:SECTOR_LSB];
                  busy_cnt_d = ERASE_LOAD;
               end
            end
            OP_BULK_ERASE: begin
               if (state_q == ST_IGNORE && latch_q) begin
                  erase_all_valid_d = 1'b1;
                  busy_cnt_d = ERASE_LOAD;
               end
            end
            default: begin
            end
         endcase
      end
      standby_d = sel_s && busy_cnt_d == '0;
      status_d = STAT_RESET;
      status_d[STAT_BUSY_BIT] = busy_cnt_d != '0;
      status_d[STAT_LATCH_BIT] = latch_d;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_OPCODE;
         tgl_seen_q <= 1'b0;
         sel_prev_q <= 1'b0;
         armed_q <= 1'b0;
         opcode_q <= 8'h00;
         addr_cnt_q <= 2'h0;
         addr_q <= '0;
         data_cnt_q <= 9'h000;
         latch_q <= 1'b0;
         busy_cnt_q <= '0;
         prog_valid <= 1'b0;
         prog_data <= 8'h00;
         prog_addr_q <= '0;
         erase_sector_valid <= 1'b0;
         erase_all_valid <= 1'b0;
         erase_sector <= '0;
         standby <= 1'b1;
         status_q <= STAT_RESET;
      end else begin
         state_q <= state_d;
         tgl_seen_q <= tgl_seen_d;
         sel_prev_q <= sel_prev_d;
         armed_q <= armed_d;
         opcode_q <= opcode_d;
         addr_cnt_q <= addr_cnt_d;
         addr_q <= addr_d;
         data_cnt_q <= data_cnt_d;
         latch_q <= latch_d;
         busy_cnt_q <= busy_cnt_d;
         prog_valid <= prog_valid_d;
         prog_data <= prog_data_d;
         prog_addr_q <= prog_addr_d;
         erase_sector_valid <= erase_sector_valid_d;
         erase_all_valid <= erase_all_valid_d;
         erase_sector <= erase_sector_d;
         standby <= standby_d;
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs from flops
   // ----------------------------------------------------------------
   assign prog_sector = prog_addr_q[ADDR_W-1:SECTOR_LSB];
   assign prog_page = prog_addr_q[SECTOR_LSB-1:PAGE_LSB];
   assign prog_byte = prog_addr_q[BYTE_W-1:0];
   assign busy = status_q[STAT_BUSY_BIT];
   assign write_enable_latch = status_q[STAT_LATCH_BIT];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_NO_CMD_UNARMED: assert property (@(posedge clk) disable iff (reset)
      !armed_q |=> !prog_valid && !erase_sector_valid && !erase_all_valid)
      else $error("command acted on before first select edge");

   AST_STANDBY_WAITS: assert property (@(posedge clk) disable iff (reset)
      busy_cnt_q > BUSY_W'(1) |=> !standby)
      else $error("standby entered during internal cycle");

   AST_ACTIVE_SEL: assert property (@(posedge clk) disable iff (reset)
      !reset && !sel_s |=> !standby)
      else $error("selected device not active");

   AST_PAGE_LIMIT: assert property (@(posedge clk) disable iff (reset)
      prog_valid |-> data_cnt_q != 9'h000 && data_cnt_q <= PAGE_BYTES)
      else $error("page program byte count out of range");

   AST_PROG_LATCH: assert property (@(posedge clk) disable iff (reset)
      prog_valid |-> $past(latch_q) && $past(busy_cnt_q) == '0)
      else $error("program without write-enable latch");

   AST_ERASE_LATCH: assert property (@(posedge clk) disable iff (reset)
      (erase_sector_valid || erase_all_valid) |->
         $past(latch_q) && busy_cnt_q == ERASE_LOAD)
      else $error("erase without latch or without busy load");

   AST_SECTOR_SPLIT: assert property (@(posedge clk) disable iff (reset)
      erase_sector_valid |-> erase_sector == addr_q[ADDR_W-1:SECTOR_LSB])
      else $error("erase sector not taken from top address bits");

   AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (reset)
      prog_valid |=>
         prog_byte == $past(prog_byte) + 8'h01 &&
         prog_page == $past(prog_page))
      else $error("program address left its page");
endmodule : sfsfe_top

// File: testbench/sfsfe_master.sv
/*
   Bus master model for the front end: mode 0 frames on a 12 ns link clock.
   Assumes the bench calls one task at a time, off the core clock edges.
*/
module sfsfe_master (
   output logic sck,
   output logic sel_n,
   output logic mosi,
   output logic hold_n,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sck = 1'b0;
      sel_n = 1'b0;
      mosi = 1'b0;
      hold_n = 1'b1;
   end

   task automatic frame_start();
      sel_n = 1'b0;
      #24;
   endtask : frame_start

   task automatic frame_end();
      #30;
      sel_n = 1'b1;
      mosi = ~mosi;
      #30;
   endtask : frame_end

   // msb first; data set before the rise, read back at the rise
   task automatic shift(input logic [7:0] v, input int n,
                        output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         #1 mosi = v[7-i];
         #5 sck = 1'b1;
         r = {r[6:0], miso};
         #6 sck = 1'b0;
      end
   endtask : shift

   // clock and data wiggle while paused; only used while selected
   task automatic pause();
      #3 hold_n = 1'b0;
      for (int i = 0; i < 3; i++) begin
         #6 sck = 1'b1;
         mosi = ~mosi;
         #6 sck = 1'b0;
      end
      // release while sck is high so the next fall re-drives the output
      #6 sck = 1'b1;
      #3 hold_n = 1'b1;
      #3 sck = 1'b0;
      #6;
   endtask : pause
endmodule : sfsfe_master

// File: testbench/serial_flash_spi_front_end_test.sv
/*
   Self-checking bench of the front end with a serial master model.
   Assumes the design package and the master model are compiled first.
*/
module serial_flash_spi_front_end_test import sfsfe_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------
   localparam int PROG_N = 20;
   localparam int ERASE_N = 40;
   logic clk, reset, sck, sel_n, mosi, hold_n, miso_o, miso_oe;
   logic prog_valid, erase_sector_valid, erase_all_valid;
   logic busy, standby, write_enable_latch;
   logic [SECTOR_W-1:0] prog_sector, erase_sector, sec_seen;
   logic [PAGE_W-1:0] prog_page;
   logic [BYTE_W-1:0] prog_byte;
   logic [7:0] prog_data, r;
   logic [31:0] addr_q [$];
   logic [7:0] data_q [$];
   int num_errors = 0;
   int n_compared = 0;
   int n_sec = 0;
   int n_all = 0;
   wire miso = miso_oe ? miso_o : 1'bz;

   sfsfe_top #(.PROG_CNT(PROG_N), .ERASE_CNT(ERASE_N)) dut (
      .clk(clk), .reset(reset), .sck(sck), .sel_n(sel_n), .mosi(mosi),
      .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe),
      .prog_valid(prog_valid), .prog_sector(prog_sector),
      .prog_page(prog_page), .prog_byte(prog_byte),
      .prog_data(prog_data), .erase_sector_valid(erase_sector_valid),
      .erase_sector(erase_sector), .erase_all_valid(erase_all_valid),
      .busy(busy), .standby(standby),
      .write_enable_latch(write_enable_latch));
   sfsfe_master m (.sck(sck), .sel_n(sel_n), .mosi(mosi),
      .hold_n(hold_n), .miso(miso));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      if (prog_valid === 1'b1) begin
         addr_q.push_back({prog_sector, prog_page, prog_byte});
         data_q.push_back(prog_data);
      end
      if (erase_sector_valid === 1'b1) begin
         n_sec++;
         sec_seen = erase_sector;
      end
      if (erase_all_valid === 1'b1)
         n_all++;
      if (hold_n === 1'b0 || sel_n === 1'b1)
         check("miso_oe", miso_oe, 1'b0);
   end

   task automatic frame(input logic [7:0] b [$]);
      logic [7:0] x;
      m.frame_start();
      foreach (b[i])
         m.shift(b[i], 8, x);
      m.frame_end();
   endtask : frame

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n > ERASE_N + 50) begin
            num_errors++;
            finish_test();
         end
      end
      repeat (3) @(posedge clk);
      check("standby", standby, 1'b1);
      check("latch", write_enable_latch, 1'b0);
      @(negedge clk);
   endtask : wait_idle
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_no_fall();
      frame('{OP_WRITE_ENABLE});
      check("latch", write_enable_latch, 1'b0);
      $display("test no_fall done");
   endtask : t_no_fall

   task automatic t_status();
      frame('{OP_WRITE_ENABLE});
      check("latch", write_enable_latch, 1'b1);
      m.frame_start();
      m.shift(OP_READ_STATUS, 8, r);
      check("standby", standby, 1'b0);
      m.pause();
      m.shift(8'h00, 8, r);
      check("status", r, 8'h02);
      m.frame_end();
      $display("test status done");
   endtask : t_status

   task automatic t_program();
      addr_q.delete();
      data_q.delete();
      frame('{OP_PAGE_PROGRAM, 8'hff, 8'h12, 8'hfe, 8'ha5, 8'h5a, 8'hc3});
      check("count", addr_q.size(), 3);
      check("addr0", addr_q[0], 32'h3f12fe);
      check("addr1", addr_q[1], 32'h3f12ff);
      check("addr2", addr_q[2], 32'h3f1200);
      check("data0", data_q[0], 8'ha5);
      check("data2", data_q[2], 8'hc3);
      check("busy", busy, 1'b1);
      check("standby", standby, 1'b0);
      wait_idle();
      $display("test program done");
   endtask : t_program

   task automatic t_page_limit();
      logic [7:0] b [$];
      b = '{OP_PAGE_PROGRAM, 8'h01, 8'h02, 8'h00};
      for (int i = 0; i < 258; i++)
         b.push_back(i[7:0]);
      addr_q.delete();
      data_q.delete();
      frame('{OP_WRITE_ENABLE});
      frame(b);
      check("count", addr_q.size(), 256);
      check("last addr", addr_q[255], 32'h0102ff);
      check("last data", data_q[255], 8'hff);
      wait_idle();
      $display("test page_limit done");
   endtask : t_page_limit

   task automatic t_erase();
      frame('{OP_SECTOR_ERASE, 8'h05, 8'h00, 8'h00});
      check("no latch", n_sec, 0);
      check("busy", busy, 1'b0);
      frame('{OP_WRITE_ENABLE});
      frame('{OP_SECTOR_ERASE, 8'h15, 8'h00, 8'h00});
      check("sector req", n_sec, 1);
      check("sector", sec_seen, 6'h15);
      wait_idle();
      frame('{OP_WRITE_ENABLE});
      frame('{OP_BULK_ERASE});
      check("bulk req", n_all, 1);
      check("busy", busy, 1'b1);
      wait_idle();
      $display("test erase done");
   endtask : t_erase

   task automatic t_hold();
      m.frame_start();
      m.shift(OP_WRITE_ENABLE, 4, r);
      m.pause();
      check("sel standby", standby, 1'b0);
      m.shift(8'h60, 4, r);
      m.frame_end();
      check("latch", write_enable_latch, 1'b1);
      frame('{OP_WRITE_DISABLE});
      check("latch", write_enable_latch, 1'b0);
      $display("test hold done");
   endtask : t_hold

   initial begin
      reset = 1'b1;
      repeat (12) @(posedge clk);
      check("standby", standby, 1'b1);
      check("busy", busy, 1'b0);
      check("latch", write_enable_latch, 1'b0);
      reset <= 1'b0;
      repeat (4) @(negedge clk);
      t_no_fall();
      t_status();
      t_program();
      t_page_limit();
      t_erase();
      t_hold();
      finish_test();
   end
endmodule : serial_flash_spi_front_end_test
